// [rtl/rid_decode.sv]
`timescale 1ns/1ns
`include "rid_map.svh"

module rid_decode #(
	parameter bit HAS_RANGE = 1'b1,
	parameter bit HAS_LARGE = 1'b1,
	parameter bit HAS_BCAST = 1'b1
) (
	input  wire logic              clk,                    // 125 MHz clock
	input  wire logic              rstn,                   // sync reset, low
	input  wire logic              cmd_valid,              // command strobe
	input  wire rid_pkg::rid_cmd_t cmd,                    // command fields
	input  wire logic              sync_req,               // sync command strobe
	input  wire logic [7:0]        reg_addr,               // register byte address
	input  wire logic [31:0]       reg_wdata,              // write data
	input  wire logic              reg_wr,                 // write strobe
	input  wire logic              reg_rd,                 // read strobe
	output logic [31:0]            reg_rdata,              // read data, next cycle
	output rid_pkg::rid_res_t      res,                    // decoded invalidation
	output logic                   illegal_command_error,  // rejected command pulse
	output logic                   sync_done,              // sync completion pulse
	output logic                   range_support_flag      // capability flag
);
	import rid_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [2:0]  ctrl;
	logic        ill_sticky;
	logic [15:0] ill_cnt;
	logic [31:0] next_rdata;

	wire [2:0] cap_word = {HAS_BCAST, HAS_LARGE, HAS_RANGE};
	wire       range_on = HAS_RANGE & ctrl[`RID_CAP_RANGE];
	wire       large_on = HAS_LARGE & ctrl[`RID_CAP_LARGE];
	wire       bcast_on = HAS_BCAST & ctrl[`RID_CAP_BCAST];
	wire       sel_cap  = reg_addr == `RID_OFS_CAP;
	wire       sel_ctrl = reg_addr == `RID_OFS_CTRL;
	wire       sel_stat = reg_addr == `RID_OFS_STAT;
	wire       clr_ill  = reg_wr & sel_stat & reg_wdata[`RID_STAT_ILL];

	always_comb
	begin
		next_rdata = 32'h0;
		if (sel_cap)
			next_rdata = {29'h0, cap_word};
		else if (sel_ctrl)
			next_rdata = {29'h0, ctrl};
		else if (sel_stat)
			next_rdata = {ill_cnt, 15'h0, ill_sticky};
	end

	////////////////////////////////////////////////////////////////////////////
	// field decode

	// broadcast ops dropped unless broadcast maintenance enabled
	wire       take     = cmd_valid & (~cmd.bcast | bcast_on);
	// with range support off every range and hint field reads as zero
	wire [1:0] gran     = range_on ? cmd.fields[`RID_GRAN_HI:`RID_GRAN_LO] : 2'h0;
	wire       gran_set = gran != 2'h0;
	wire [1:0] ttl_raw  = gran_set ? cmd.fields[`RID_TTL_HI:`RID_TTL_LO] : 2'h0;
	// reserved 16KB level-1 hint degrades to any-level
	wire       ttl_deg  = (gran == 2'h2) & ~large_on & (ttl_raw == 2'h1);
	wire [1:0] ttl_eff  = ttl_deg ? 2'h0 : ttl_raw;
	wire       wide     = (ttl_eff != 2'h0) & cmd.fields[`RID_WIDE_BIT];
	wire [5:0] scale_f  = {cmd.fields[`RID_SCALE_HI] & large_on,
	                       cmd.fields[`RID_SCALE_HI-1:`RID_SCALE_LO]};
	wire [5:0] scale_c  = (scale_f > `RID_SCALE_MAX) ? `RID_SCALE_MAX : scale_f;
	wire [5:0] scale    = gran_set ? scale_c : 6'h0;
	wire [4:0] num      = gran_set ? cmd.fields[`RID_NUM_HI:`RID_NUM_LO] : 5'h0;
	wire       illegal  = gran_set & (num == 5'h0) & (scale == 6'h0)
	                      & (ttl_eff == 2'h0);

	////////////////////////////////////////////////////////////////////////////
	// span arithmetic in 4KB page units, 53 bits so nothing overflows

	wire [2:0]  gshift  = (gran == 2'h3) ? 3'h4 : (gran == 2'h2) ? 3'h2 : 3'h0;
	wire [5:0]  sh      = scale + {3'h0, gshift};
	wire [5:0]  num_p1  = {1'b0, num} + 6'h1;
	wire [52:0] span_pg = {47'h0, num_p1} << sh;
	wire [52:0] end_raw = {1'b0, cmd.addr} + (gran_set ? span_pg : 53'h1);
	// clip at the top of the base address half, no wrap
	wire [52:0] limit   = cmd.addr[51] ? `RID_LIMIT_HI : `RID_LIMIT_LO;
	wire [52:0] end_pg  = (end_raw > limit) ? limit : end_raw;

	////////////////////////////////////////////////////////////////////////////
	// alignment and table levels

	function automatic logic [5:0] wide_low_bits(input logic [1:0] g, input logic [1:0] l);
		logic [5:0] n;
		n = 6'h0;
		unique case ({g, l})
			4'b0101: n = 6'd16;
			4'b0110: n = 6'd8;
			4'b1001: n = 6'd22;
			4'b1010: n = 6'd12;
			4'b1011: n = 6'd2;
			4'b1101: n = 6'd28;
			4'b1110: n = 6'd16;
			4'b1111: n = 6'd4;
			default: n = 6'h0;
		endcase
		return n;
	endfunction : wide_low_bits

	wire [5:0]  low_n   = wide_low_bits(gran, ttl_eff);
	wire [51:0] low_msk = ~({52{1'b1}} << low_n);
	// misaligned base on 128-bit descriptors: allowed to do nothing
	wire        skip    = wide & ((cmd.addr & low_msk) != 52'h0);
	wire [3:0]  tables  = (cmd.leaf | (ttl_eff == 2'h0)) ? 4'h0
	                      : ~(4'hf << ttl_eff);

	rid_res_t next_res;

	always_comb
	begin
		next_res          = '0;
		next_res.valid    = take & ~illegal;
		next_res.bcast    = cmd.bcast;
		next_res.range_en = gran_set;
		next_res.gran     = gran;
		next_res.level    = ttl_eff;
		next_res.wide     = wide;
		next_res.leaf     = cmd.leaf;
		next_res.tables   = tables;
		next_res.skip     = skip;
		next_res.start_pg = cmd.addr;
		next_res.end_pg   = end_pg;
	end

	wire ill_set = take & illegal;

	////////////////////////////////////////////////////////////////////////////
	// state

	// control register, reset enables every feature the build has
	always_ff @(posedge clk)
	begin
		if (!rstn)
			ctrl <= `RID_CTRL_RESET;
		else if (reg_wr & sel_ctrl)
			ctrl <= reg_wdata[2:0];
	end

	// sticky flag: a new rejection wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			ill_sticky <= 1'b0;
			ill_cnt    <= 16'h0;
		end
		else
		begin
			ill_sticky <= ill_set | (ill_sticky & ~clr_ill);
			ill_cnt    <= ill_cnt + {15'h0, ill_set};
		end
	end

	// read data stands for one cycle only
	always_ff @(posedge clk)
	begin
		if (!rstn)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? next_rdata : 32'h0;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			res                   <= '0;
			illegal_command_error <= 1'b0;
		end
		else
		begin
			res                   <= next_res;
			illegal_command_error <= ill_set;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			sync_done          <= 1'b0;
			range_support_flag <= 1'b0;
		end
		else
		begin
			// one-stage pipe: earlier results leave no later than this pulse
			sync_done          <= sync_req;
			range_support_flag <= HAS_RANGE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_sync_done;
		sync_req |=> sync_done;
	endproperty
	a_sync_done: assert property (p_sync_done) else $error("sync not completed");

	property p_reserved;
		take && gran_set && num == 5'h0 && scale == 6'h0 && ttl_eff == 2'h0
			|=> illegal_command_error && !res.valid;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved encoding accepted");

	property p_16k_l1;
		take && range_on && !large_on && cmd.fields[75:72] == 4'b1001
			&& cmd.fields[24:20] == 5'h0 && cmd.fields[16:12] == 5'h0
			|=> illegal_command_error;
	endproperty
	a_16k_l1: assert property (p_16k_l1) else $error("16KB level-1 single not rejected");

	property p_tg_zero;
		res.valid && res.gran == 2'h0 |-> res.level == 2'h0 && !res.wide && !res.range_en;
	endproperty
	a_tg_zero: assert property (p_tg_zero) else $error("hint used with granule zero");

	property p_range_off;
		take && !range_on |=> res.valid && !res.range_en && res.level == 2'h0;
	endproperty
	a_range_off: assert property (p_range_off) else $error("range used while disabled");

	property p_span_order;
		res.valid && res.range_en |-> res.end_pg > {1'b0, res.start_pg};
	endproperty
	a_span_order: assert property (p_span_order) else $error("empty span");

	property p_no_wrap;
		res.valid |-> res.end_pg <= (res.start_pg[51] ? `RID_LIMIT_HI : `RID_LIMIT_LO);
	endproperty
	a_no_wrap: assert property (p_no_wrap) else $error("span wrapped");

	property p_tables;
		res.valid && !res.leaf && res.level == 2'h2 |-> res.tables == 4'h3;
	endproperty
	a_tables: assert property (p_tables) else $error("table levels wrong");

	property p_bcast;
		cmd_valid && cmd.bcast && !bcast_on |=> !res.valid && !illegal_command_error;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast taken while off");

	property p_max_span;
		take && gran == 2'h3 && scale == `RID_SCALE_MAX && num == 5'h1f && !cmd.addr[51]
			&& cmd.addr == 52'h0 |=> res.end_pg == 53'h1000000000000;
	endproperty
	a_max_span: assert property (p_max_span) else $error("maximum span wrong");

	////////////////////////////////////////////////////////////////////////////
	// further checks, some built on named sequences

	sequence s_legal_cmd;
		take && !illegal;
	endsequence

	sequence s_range_cmd;
		take && range_on && !illegal
			&& cmd.fields[`RID_GRAN_HI:`RID_GRAN_LO] != 2'h0;
	endsequence

	sequence s_span_4k;
		take && range_on && !illegal && cmd.fields[`RID_GRAN_HI:`RID_GRAN_LO] == 2'h1
			&& cmd.addr == 52'h0;
	endsequence

	sequence s_stat_read;
		reg_rd && sel_stat;
	endsequence

	property p_flag;
		$past(rstn) |-> range_support_flag == HAS_RANGE;
	endproperty
	a_flag: assert property (p_flag) else $error("capability flag wrong");

	property p_cap_read;
		reg_rd && sel_cap |=> reg_rdata == {29'h0, HAS_BCAST, HAS_LARGE, HAS_RANGE};
	endproperty
	a_cap_read: assert property (p_cap_read) else $error("capability read wrong");

	property p_rdata_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

	property p_ctrl_write;
		reg_wr && sel_ctrl |=> ctrl == $past(reg_wdata[2:0]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_narrow;
		take && !large_on |-> !scale[5];
	endproperty
	a_narrow: assert property (p_narrow) else $error("exponent top bit used");

	property p_clamp;
		take && gran_set && large_on
			&& cmd.fields[`RID_SCALE_HI:`RID_SCALE_LO] > `RID_SCALE_MAX |-> scale == `RID_SCALE_MAX;
	endproperty
	a_clamp: assert property (p_clamp) else $error("exponent not clamped");

	property p_num_zero;
		take && !gran_set |-> num == 5'h0 && scale == 6'h0;
	endproperty
	a_num_zero: assert property (p_num_zero) else $error("count used with granule zero");

	property p_gran;
		s_range_cmd |=> res.valid && res.range_en
			&& res.gran == $past(cmd.fields[`RID_GRAN_HI:`RID_GRAN_LO]);
	endproperty
	a_gran: assert property (p_gran) else $error("granule code lost");

	property p_level;
		s_range_cmd ##0 !ttl_deg
			|=> res.level == $past(cmd.fields[`RID_TTL_HI:`RID_TTL_LO]);
	endproperty
	a_level: assert property (p_level) else $error("level hint lost");

	property p_degrade;
		take && ttl_deg |=> res.level == 2'h0;
	endproperty
	a_degrade: assert property (p_degrade) else $error("reserved hint not degraded");

	property p_wide;
		res.valid && res.wide |-> res.level != 2'h0 && res.gran != 2'h0;
	endproperty
	a_wide: assert property (p_wide) else $error("wide hint without level");

	property p_span_4k;
		s_span_4k |=> res.end_pg
			== ((53'($past(cmd.fields[`RID_NUM_HI:`RID_NUM_LO])) + 53'h1) << $past(scale));
	endproperty
	a_span_4k: assert property (p_span_4k) else $error("span size wrong");

	property p_start;
		s_legal_cmd |=> res.start_pg == $past(cmd.addr);
	endproperty
	a_start: assert property (p_start) else $error("span start wrong");

	property p_upper_clip;
		s_legal_cmd ##0 cmd.addr[51]
			|=> res.end_pg <= `RID_LIMIT_HI && res.end_pg > {1'b0, res.start_pg};
	endproperty
	a_upper_clip: assert property (p_upper_clip) else $error("upper span wrapped");

	property p_ill_count;
		take && illegal |=> ill_sticky && ill_cnt == $past(ill_cnt) + 16'h1;
	endproperty
	a_ill_count: assert property (p_ill_count) else $error("rejection not recorded");

	property p_stat_read;
		s_stat_read |=> reg_rdata == {$past(ill_cnt), 15'h0, $past(ill_sticky)};
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("status read wrong");

	property p_skip;
		res.skip |-> res.wide;
	endproperty
	a_skip: assert property (p_skip) else $error("skip without wide hint");

	property p_leaf;
		res.valid && res.leaf |-> res.tables == 4'h0;
	endproperty
	a_leaf: assert property (p_leaf) else $error("leaf command hit tables");

	property p_bcast_on;
		cmd_valid && cmd.bcast && bcast_on && !illegal |=> res.valid && res.bcast;
	endproperty
	a_bcast_on: assert property (p_bcast_on) else $error("broadcast dropped while on");

	property p_sync_after;
		s_legal_cmd ##0 sync_req |=> res.valid && sync_done;
	endproperty
	a_sync_after: assert property (p_sync_after) else $error("sync ahead of result");

	property p_idle;
		!take |=> !illegal_command_error && !res.valid;
	endproperty
	a_idle: assert property (p_idle) else $error("output without command");

endmodule : rid_decode

// [inc/rid_map.svh]
`ifndef RID_MAP_SVH
`define RID_MAP_SVH

`define RID_OFS_CAP        8'h00
`define RID_OFS_CTRL       8'h04
`define RID_OFS_STAT       8'h08

`define RID_CAP_RANGE      0
`define RID_CAP_LARGE      1
`define RID_CAP_BCAST      2
`define RID_STAT_ILL       0
`define RID_STAT_CNT_LO    16
`define RID_CTRL_RESET     3'h7

`define RID_SCALE_HI       25
`define RID_SCALE_LO       20
`define RID_NUM_HI         16
`define RID_NUM_LO         12
`define RID_GRAN_HI        75
`define RID_GRAN_LO        74
`define RID_TTL_HI         73
`define RID_TTL_LO         72
`define RID_WIDE_BIT       71

`define RID_SCALE_MAX      6'h27
`define RID_LIMIT_HI       53'h10000000000000
`define RID_LIMIT_LO       53'h08000000000000

`endif

// [inc/rid_pkg.sv]
package rid_pkg;

	typedef struct packed {
		logic        bcast;   // arrived by broadcast
		logic        leaf;    // leaf-only scope
		logic [75:0] fields;  // command bits 75:0
		logic [51:0] addr;    // base address bits 63:12
	} rid_cmd_t;

	typedef struct packed {
		logic        valid;
		logic        bcast;
		logic        range_en;
		logic [1:0]  gran;
		logic [1:0]  level;
		logic        wide;
		logic        leaf;
		logic [3:0]  tables;
		logic        skip;
		logic [51:0] start_pg;
		logic [52:0] end_pg;
	} rid_res_t;

endpackage : rid_pkg

// [testbench/rid_sw_model.sv]
`timescale 1ns/1ns
module rid_sw_model (
	input  wire logic              clk,       // device clock
	input  wire logic              rstn,      // sync reset, low
	input  wire logic              push,      // queue one command
	input  wire rid_pkg::rid_cmd_t push_cmd,  // command to queue
	output logic                   cmd_valid, // command strobe
	output rid_pkg::rid_cmd_t      cmd        // command fields
);
	import rid_pkg::*;
	////////////////////////////////////////////////////////////////////////////////
	// one queue slot; idle fields invert every cycle so stale values never stay steady
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			cmd_valid <= 1'b0;
			cmd       <= '0;
		end
		else
		begin
			cmd_valid <= push;
			cmd       <= push ? push_cmd : ~cmd;
		end
	end
endmodule : rid_sw_model

// [testbench/rid_decode_test.sv]
`timescale 1ns/1ns
module rid_decode_test;
	import rid_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        push = 1'b0;
	logic        sync_req = 1'b0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] rd_val;
	logic        cmd_valid, ill, sync_done, flag, got_ill;
	rid_cmd_t    push_cmd = '0;
	rid_cmd_t    cmd;
	rid_res_t    res, got;
	int          error_cnt = 0;
	int          num_checks = 0;
	always #4 clk = ~clk;
	rid_sw_model rid_sw_model_inst (.clk(clk), .rstn(rstn), .push(push), .push_cmd(push_cmd),
		.cmd_valid(cmd_valid), .cmd(cmd));
	rid_decode rid_decode_inst (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd(cmd),
		.sync_req(sync_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .res(res), .illegal_command_error(ill),
		.sync_done(sync_done), .range_support_flag(flag));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask : rd
	task automatic issue(input logic [1:0] gc, ttl, input logic [5:0] sc, input logic [4:0] n,
		input logic w, lf, bc, input logic [51:0] a);
		@(posedge clk);
		push_cmd <= '{bc, lf, {gc, ttl, w, 45'h0, sc, 3'h0, n, 12'h0}, a};
		push     <= 1'b1;
		@(posedge clk);
		push     <= 1'b0;
		@(posedge clk);
		#1 got = res;
		got_ill = ill;
	endtask : issue
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_caps;
		chk("flag", 1, flag);
		rd(8'h00);
		chk("cap", 7, rd_val);
		@(posedge clk);
		#1 chk("rdidle", 0, reg_rdata);
		rd(8'h0c);
		chk("unmapped", 0, rd_val);
		$display("caps done");
	endtask : t_caps
	task automatic t_span;
		for (int g = 1; g < 4; g++)
		begin
			issue(2'(g), 2'h3, 6'h0, 5'h1, 0, 1, 0, 52'h100);
			chk("gran", g, got.gran);
			chk("start", 52'h100, got.start_pg);
			chk("end", 52'h100 + (2 << (2 * g - 2)), got.end_pg);
		end
		issue(2'h1, 2'h0, 6'h3f, 5'h0, 0, 1, 0, 52'h0);
		chk("clamp", 64'h80_0000_0000, got.end_pg);
		issue(2'h3, 2'h0, 6'h27, 5'h1f, 0, 1, 0, 52'h0);
		chk("max", 64'h1_0000_0000_0000, got.end_pg);
		issue(2'h1, 2'h3, 6'h0, 5'h3, 0, 1, 0, 52'hf_ffff_ffff_fffe);
		chk("top", 64'h10_0000_0000_0000, got.end_pg);
		issue(2'h1, 2'h3, 6'h0, 5'h3, 0, 1, 0, 52'h7_ffff_ffff_fffe);
		chk("mid", 64'h8_0000_0000_0000, got.end_pg);
		$display("span done");
	endtask : t_span
	task automatic t_illegal;
		issue(2'h1, 2'h0, 6'h0, 5'h0, 0, 1, 0, 52'h40);
		chk("ill", 1, got_ill);
		chk("valid", 0, got.valid);
		rd(8'h08);
		chk("stat", 1, rd_val[0]);
		chk("count", 1, rd_val[31:16]);
		wr(8'h08, 32'h1);
		rd(8'h08);
		chk("clear", 0, rd_val[0]);
		chk("kept", 1, rd_val[31:16]);
		issue(2'h0, 2'h3, 6'h5, 5'h7, 0, 1, 0, 52'h40);
		chk("range", 0, got.range_en);
		chk("level", 0, got.level);
		chk("end", 52'h41, got.end_pg);
		$display("illegal done");
	endtask : t_illegal
	task automatic t_levels;
		for (int l = 1; l < 4; l++)
		begin
			issue(2'h1, 2'(l), 6'h0, 5'h0, 1, 0, 0, 52'h0);
			chk("level", l, got.level);
			chk("tables", ~(4'hf << l) & 4'hf, got.tables);
			chk("wide", 1, got.wide);
			chk("skip", 0, got.skip);
		end
		issue(2'h1, 2'h2, 6'h0, 5'h0, 0, 1, 0, 52'h0);
		chk("leaf", 0, got.tables);
		chk("leafbit", 1, got.leaf);
		issue(2'h1, 2'h0, 6'h0, 5'h1, 1, 1, 0, 52'h0);
		chk("wide0", 0, got.wide);
		issue(2'h1, 2'h1, 6'h0, 5'h0, 1, 1, 0, 52'h1);
		chk("skip", 1, got.skip);
		$display("levels done");
	endtask : t_levels
	task automatic t_modes;
		wr(8'h04, 32'h5);
		rd(8'h04);
		chk("ctrl", 5, rd_val);
		issue(2'h1, 2'h0, 6'h21, 5'h0, 0, 1, 0, 52'h10);
		chk("narrow", 52'h12, got.end_pg);
		issue(2'h2, 2'h1, 6'h0, 5'h1, 0, 1, 0, 52'h100);
		chk("degrade", 0, got.level);
		issue(2'h2, 2'h1, 6'h0, 5'h0, 0, 1, 0, 52'h100);
		chk("ill", 1, got_ill);
		wr(8'h04, 32'h6);
		issue(2'h1, 2'h3, 6'h0, 5'h3, 0, 1, 0, 52'h20);
		chk("range", 0, got.range_en);
		chk("end", 52'h21, got.end_pg);
		wr(8'h04, 32'h3);
		issue(2'h1, 2'h3, 6'h0, 5'h1, 0, 1, 1, 52'h20);
		chk("drop", 0, got.valid | got_ill);
		wr(8'h04, 32'h7);
		issue(2'h1, 2'h3, 6'h0, 5'h1, 0, 1, 1, 52'h20);
		chk("bcast", 1, got.valid & got.bcast);
		@(posedge clk);
		sync_req <= 1'b1;
		@(posedge clk);
		sync_req <= 1'b0;
		#1 chk("sync", 1, sync_done);
		$display("modes done");
	endtask : t_modes
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1 t_caps;
		t_span;
		t_illegal;
		t_levels;
		t_modes;
		report_and_stop;
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end
endmodule : rid_decode_test
